/* include/embh_pkg.sv */
// embh_pkg: constants and types for the external memory bus and hold control
`default_nettype none
package embh_pkg;
	// ------------------------------------------------------------
	// bus widths
	// ------------------------------------------------------------
	localparam int EMBH_DW        = 32;
	localparam int EMBH_AW        = 20;
	localparam int EMBH_CEW       = 4;
	localparam int EMBH_BEW       = 4;
	// ------------------------------------------------------------
	// counts and reset values
	// ------------------------------------------------------------
	localparam int EMBH_FIFO_DEPTH = 4;
	localparam int EMBH_BURST_MAX  = 8;
	localparam int EMBH_RDY_MIN    = 4;
	localparam logic [3:0] EMBH_CE_IDLE = 4'hF;
	localparam logic [3:0] EMBH_BE_IDLE = 4'hF;
	localparam logic [3:0] EMBH_RST_CNT = 4'h0;
	// ------------------------------------------------------------
	// memory kinds and bus states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		EMBH_MEM_ASYNC = 2'h0,
		EMBH_MEM_BURST = 2'h1,
		EMBH_MEM_DRAM  = 2'h2
	} embh_mem_t;
	typedef enum logic [2:0] {
		EMBH_IDLE  = 3'h0,
		EMBH_LEAD  = 3'h1,
		EMBH_XFER  = 3'h3,
		EMBH_WAIT  = 3'h2,
		EMBH_HOLD  = 3'h6
	} embh_state_t;
endpackage : embh_pkg
`default_nettype wire

/* rtl/embh_fifo.sv */
// embh_fifo: small request fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module embh_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wp_r;
	logic [PW-1:0]    rp_r;
	logic [PW:0]      cnt_r;
	logic             push;
	logic             pop;
	logic [PW:0]      cnt_nxt;
	// ready leaves a flop, so the source never sees a comparator path
	assign cnt_nxt   = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem[rp_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
			in_ready <= 1'b1;
		end else begin
			if (push) begin
				wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r    <= cnt_nxt;
			in_ready <= (cnt_nxt != (PW+1)'(DEPTH));
		end
	end
endmodule : embh_fifo
`default_nettype wire

/* rtl/embh_ctrl.sv */
// embh_ctrl: external memory bus sequencer with bus hold handshake
//
// Summary of operation
// - burst sram: shared pins are addr strobe, oe, we
// - dram: shared pins are column, row, write strobes
// - first write of a run: data one cycle early
// - transfer in progress finishes before grant is given; queued words wait
// - async ready stretches grant wait; burst limit does not
// - idle bus grants hold with minimum delay
// - grant block bit postpones hold indefinitely
// - surrendered bus: selects, lanes, data, address, strobes
// - in reset grant ack and fifo clock high
// - in reset all memory pins high impedance
`timescale 1ns/1ps
`default_nettype none
module embh_ctrl
	import embh_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                rstn,
	input  wire logic                req_valid,
	output logic                     req_ready,
	input  wire logic                req_write,
	input  wire embh_mem_t           req_kind,
	input  wire logic [EMBH_AW-1:0]  req_addr,
	input  wire logic [EMBH_DW-1:0]  req_wdata,
	input  wire logic [EMBH_CEW-1:0] req_ce_n,
	input  wire logic [EMBH_BEW-1:0] req_be_n,
	input  wire logic                burst_limit_bit,
	input  wire logic                grant_block_bit,
	input  wire logic                hold_req,
	input  wire logic                async_ready,
	output logic                     bus_grant_ack,
	output logic                     fifo_clock_out,
	output logic                     memory_clock_out,
	output logic [EMBH_AW-1:0]       mem_addr_bus,
	output logic [EMBH_DW-1:0]       mem_data_bus_o,
	output logic                     mem_data_bus_oe,
	output logic [EMBH_CEW-1:0]      chip_sel_n,
	output logic [EMBH_BEW-1:0]      byte_lane_strobe_n,
	output logic                     async_out_enable_n,
	output logic                     async_write_strobe_n,
	output logic                     async_read_strobe_n,
	output logic                     shared_ctl0_n,
	output logic                     shared_ctl1_n,
	output logic                     shared_ctl2_n,
	output logic                     dram_addr_bit_ten,
	output logic                     mem_bus_oe
);
	// ------------------------------------------------------------
	// request buffer; ready goes straight back to the source
	// ------------------------------------------------------------
	localparam int FW = 1 + 2 + EMBH_AW + EMBH_DW + EMBH_CEW + EMBH_BEW;
	logic          f_valid;
	logic          f_ready;
	logic [FW-1:0] f_data;
	logic          f_wr;
	embh_mem_t     f_kind;
	logic [1:0]    f_kind_bits;
	logic [EMBH_AW-1:0]  f_addr;
	logic [EMBH_DW-1:0]  f_wd;
	logic [EMBH_CEW-1:0] f_ce;
	logic [EMBH_BEW-1:0] f_be;
	embh_fifo #(.WIDTH(FW), .DEPTH(EMBH_FIFO_DEPTH)) u_fifo (
		.clk      (ref_clk),
		.rstn     (rstn),
		.in_valid (req_valid),
		.in_ready (req_ready),
		.in_data  ({req_write, req_kind, req_addr, req_wdata, req_ce_n, req_be_n}),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data (f_data)
	);
	assign {f_wr, f_kind_bits, f_addr, f_wd, f_ce, f_be} = f_data;
	assign f_kind = embh_mem_t'(f_kind_bits);

	// ------------------------------------------------------------
	// pin synchronisers: three stages, change on stage 2 == 3
	// ------------------------------------------------------------
	logic [2:0] hold_s_r;
	logic [2:0] rdy_s_r;
	logic       hold_q_r;
	logic       rdy_q_r;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hold_s_r <= 3'h0;
			rdy_s_r  <= 3'h7;
			hold_q_r <= 1'b0;
			rdy_q_r  <= 1'b1;
		end else begin
			hold_s_r <= {hold_s_r[1:0], hold_req};
			rdy_s_r  <= {rdy_s_r[1:0], async_ready};
			if (hold_s_r[1] == hold_s_r[2]) begin
				hold_q_r <= hold_s_r[2];
			end
			if (rdy_s_r[1] == rdy_s_r[2]) begin
				rdy_q_r <= rdy_s_r[2];
			end
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	embh_state_t st_r;
	logic [3:0]  run_r;
	logic        wrun_r;
	logic        hold_ok;
	logic        take;
	// idle bus grants at once; otherwise the current transfer ends first and the run is cut
	assign hold_ok = hold_q_r && !grant_block_bit;
	assign take    = f_valid && !hold_ok && (st_r == EMBH_IDLE || st_r == EMBH_XFER);
	assign f_ready = take && !(f_wr && !wrun_r);
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r   <= EMBH_IDLE;
			run_r  <= EMBH_RST_CNT;
			wrun_r <= 1'b0;
		end else begin
			case (st_r)
				EMBH_IDLE, EMBH_XFER: begin
					if (hold_ok) begin
						st_r   <= EMBH_HOLD;
						wrun_r <= 1'b0;
					end else if (f_valid && f_wr && !wrun_r) begin
						st_r   <= EMBH_LEAD;
						wrun_r <= 1'b1;
					end else if (f_valid && f_kind == EMBH_MEM_ASYNC && !rdy_q_r) begin
						st_r <= EMBH_WAIT;
					end else if (f_valid) begin
						st_r   <= EMBH_XFER;
						wrun_r <= f_wr;
						// burst limit caps a dram run at eight
						run_r  <= (burst_limit_bit && run_r == 4'(EMBH_BURST_MAX - 1))
							? EMBH_RST_CNT : run_r + 4'h1;
					end else begin
						st_r   <= EMBH_IDLE;
						wrun_r <= 1'b0;
						run_r  <= EMBH_RST_CNT;
					end
				end
				EMBH_LEAD: st_r <= EMBH_XFER;
				EMBH_WAIT: begin
					if (rdy_q_r) begin
						st_r <= EMBH_XFER;
					end
				end
				EMBH_HOLD: begin
					if (!hold_q_r) begin
						st_r <= EMBH_IDLE;
					end
				end
				default: st_r <= EMBH_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// pin drivers, all registered
	// ------------------------------------------------------------
	logic is_b;
	logic is_d;
	logic drive;
	assign is_b  = (f_kind == EMBH_MEM_BURST);
	assign is_d  = (f_kind == EMBH_MEM_DRAM);
	assign drive = f_ready;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bus_grant_ack        <= 1'b1;
			fifo_clock_out       <= 1'b1;
			memory_clock_out     <= 1'b0;
			mem_bus_oe           <= 1'b0;
			mem_data_bus_oe      <= 1'b0;
			mem_addr_bus         <= '0;
			mem_data_bus_o       <= '0;
			chip_sel_n           <= EMBH_CE_IDLE;
			byte_lane_strobe_n   <= EMBH_BE_IDLE;
			async_out_enable_n   <= 1'b1;
			async_write_strobe_n <= 1'b1;
			async_read_strobe_n  <= 1'b1;
			shared_ctl0_n        <= 1'b1;
			shared_ctl1_n        <= 1'b1;
			shared_ctl2_n        <= 1'b1;
			dram_addr_bit_ten    <= 1'b0;
		end else begin
			memory_clock_out <= ~memory_clock_out;
			fifo_clock_out   <= ~fifo_clock_out;
			bus_grant_ack    <= (st_r == EMBH_HOLD);
			// surrendered pins float while granted
			mem_bus_oe       <= (st_r != EMBH_HOLD) && !hold_ok;
			// write data launched in lead cycle, ahead of the strobe
			mem_data_bus_oe  <= f_valid && f_wr && !hold_ok
				&& (st_r == EMBH_LEAD || wrun_r);
			mem_data_bus_o   <= f_wd;
			mem_addr_bus     <= f_addr;
			dram_addr_bit_ten <= is_d && f_addr[10];
			chip_sel_n         <= drive ? f_ce : EMBH_CE_IDLE;
			byte_lane_strobe_n <= drive ? f_be : EMBH_BE_IDLE;
			async_out_enable_n   <= !(drive && f_kind == EMBH_MEM_ASYNC && !f_wr);
			async_read_strobe_n  <= !(drive && f_kind == EMBH_MEM_ASYNC && !f_wr);
			async_write_strobe_n <= !(drive && f_kind == EMBH_MEM_ASYNC && f_wr);
			// one pin set, two meanings chosen by memory kind
			shared_ctl0_n <= !(drive && (is_b || is_d));
			shared_ctl1_n <= !(drive && ((is_b && !f_wr) || (is_d && run_r == 4'h0)));
			shared_ctl2_n <= !(drive && (is_b || is_d) && f_wr);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_ack_after_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
		$rose(bus_grant_ack) |-> $past(hold_q_r) && !$past(grant_block_bit))
		else $error("grant without hold request");
	a_block_no_ack: assert property (@(posedge ref_clk) disable iff (!rstn)
		grant_block_bit && !bus_grant_ack |=> !bus_grant_ack)
		else $error("grant despite block bit");
	a_idle_fast_grant: assert property (@(posedge ref_clk) disable iff (!rstn)
		st_r == EMBH_IDLE && hold_ok |-> ##2 bus_grant_ack)
		else $error("idle grant slow");
	a_hold_float: assert property (@(posedge ref_clk) disable iff (!rstn)
		bus_grant_ack |-> !mem_bus_oe && !mem_data_bus_oe)
		else $error("bus driven under grant");
	a_hold_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
		bus_grant_ack && hold_q_r |=> bus_grant_ack)
		else $error("grant dropped early");
	a_lead_data: assert property (@(posedge ref_clk) disable iff (!rstn)
		st_r == EMBH_LEAD |=> mem_data_bus_oe && shared_ctl2_n && async_write_strobe_n)
		else $error("early write data missing");
	a_wait_ready: assert property (@(posedge ref_clk) disable iff (!rstn)
		st_r == EMBH_WAIT && !rdy_q_r |=> st_r == EMBH_WAIT)
		else $error("ready stretch lost");
	a_burst_cap: assert property (@(posedge ref_clk) disable iff (!rstn)
		burst_limit_bit |-> run_r < 4'(EMBH_BURST_MAX))
		else $error("burst run too long");
	a_dram_we: assert property (@(posedge ref_clk) disable iff (!rstn)
		!shared_ctl2_n |-> !shared_ctl0_n)
		else $error("write strobe without address/column strobe");
	c_hold: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(bus_grant_ack));
	c_write_run: cover property (@(posedge ref_clk) disable iff (!rstn)
		st_r == EMBH_LEAD ##1 st_r == EMBH_XFER ##1 st_r == EMBH_XFER);
	c_ready_wait: cover property (@(posedge ref_clk) disable iff (!rstn)
		st_r == EMBH_WAIT ##1 st_r == EMBH_XFER);
endmodule : embh_ctrl
`default_nettype wire

/* verification/embh_far_model.sv */
// embh_far_model: async ready pin and write strobe counter plus outside bus master facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module embh_far_model (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        want_hold,
	input  wire logic        ready_now,
	input  wire logic        async_write_strobe_n,
	input  wire logic        shared_ctl2_n,
	input  wire logic        mem_bus_oe,
	output logic             hold_req,
	output logic             async_ready,
	output int               wr_count
);
	// ------------------------------------------------------------
	// outside master and ready pin
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		hold_req <= want_hold;
	end
	// slow device: ready pin follows ready_now directly, no minimum count
	assign async_ready = ready_now;
	// ------------------------------------------------------------
	// write strobes seen on a driven bus
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wr_count <= 0;
		end else if (mem_bus_oe && (!async_write_strobe_n || !shared_ctl2_n)) begin
			wr_count <= wr_count + 1;
		end
	end
endmodule : embh_far_model
`default_nettype wire

/* verification/testbench.sv */
// testbench: scenario tasks for the memory sequencer and hold handshake
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import embh_pkg::*;
	logic ref_clk = 0, rstn = 0, req_valid = 0, req_write = 0, blim = 0, gblk = 0;
	logic want_hold = 0, ready_now = 1, req_ready, hold_req, async_ready, ack;
	logic fclk, mclk, d_oe, b_oe, aoe_n, awe_n, are_n, c0, c1, c2, a10;
	embh_mem_t req_kind = EMBH_MEM_ASYNC;
	logic [EMBH_AW-1:0] req_addr = '0, ma;
	logic [EMBH_DW-1:0] req_wdata = '0, md;
	logic [3:0] ce_n, be_n;
	int wr_count, fail_count = 0, checked = 0, cyc = 0, n;
	always #4 ref_clk = ~ref_clk;
	embh_ctrl dut (.ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_kind(req_kind),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_ce_n(4'hE), .req_be_n(4'h0),
		.burst_limit_bit(blim), .grant_block_bit(gblk), .hold_req(hold_req),
		.async_ready(async_ready), .bus_grant_ack(ack), .fifo_clock_out(fclk),
		.memory_clock_out(mclk), .mem_addr_bus(ma), .mem_data_bus_o(md),
		.mem_data_bus_oe(d_oe), .chip_sel_n(ce_n), .byte_lane_strobe_n(be_n),
		.async_out_enable_n(aoe_n), .async_write_strobe_n(awe_n),
		.async_read_strobe_n(are_n), .shared_ctl0_n(c0), .shared_ctl1_n(c1),
		.shared_ctl2_n(c2), .dram_addr_bit_ten(a10), .mem_bus_oe(b_oe));
	embh_far_model far (.ref_clk(ref_clk), .rstn(rstn), .want_hold(want_hold),
		.ready_now(ready_now), .async_write_strobe_n(awe_n), .shared_ctl2_n(c2),
		.mem_bus_oe(b_oe), .hold_req(hold_req), .async_ready(async_ready),
		.wr_count(wr_count));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : step
	// one word handed to the fifo; an edge passes before the next
	task automatic send(input embh_mem_t k, input logic w, input logic [31:0] d);
		req_kind = k;
		req_write = w;
		req_wdata = d;
		req_addr = d[19:0];
		req_valid = 1;
		for (n = 0; n < 200 && req_ready !== 1'b1; n++) step(1);
		step(1);
		req_valid = 0;
		step(1);
	endtask : send
	// cycles until ack reaches the level, 99 when it never does
	task automatic wait_ack(input logic lvl, output int c);
		for (c = 0; c < 99 && ack !== lvl; c++) step(1);
	endtask : wait_ack
	task automatic complete_run;
		$display("mismatches %0d, comparisons %0d", fail_count, checked);
		if (fail_count == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_burst_write;
		logic pre, pm, pf;
		pre = 0;
		send(EMBH_MEM_BURST, 1, 32'hA5C3_0F12);
		for (n = 0; n < 20 && c2 !== 1'b0; n++) begin pre = d_oe; step(1); end
		chk("lead data oe", pre, 1);
		chk("addr strobe", c0, 0);
		chk("burst oe", c1, 1);
		chk("write data", md, 32'hA5C3_0F12);
		chk("chip select", ce_n, 4'hE);
		chk("byte lanes", be_n, 4'h0);
		chk("address", ma, 20'h30F12);
		pm = mclk;
		pf = fclk;
		step(1);
		chk("memory clock toggles", mclk, !pm);
		chk("fifo clock toggles", fclk, !pf);
		step(3);
	endtask : t_burst_write
	task automatic t_dram_read;
		logic row, we, rd;
		row = 0;
		we = 0;
		rd = 0;
		send(EMBH_MEM_DRAM, 0, 32'h0000_1234);
		repeat (20) begin row |= !c1; we |= !c2; step(1); end
		chk("row strobe", row, 1);
		chk("dram we on read", we, 0);
		send(EMBH_MEM_ASYNC, 0, 32'h0000_0055);
		repeat (10) begin rd |= !aoe_n && !are_n; we |= !awe_n; step(1); end
		chk("async read strobes", rd, 1);
		chk("async read no write", we, 0);
	endtask : t_dram_read
	// twelve dram reads back to back: row strobe again after eight
	task automatic t_burst_limit;
		int rows, strobes, hi10;
		rows = 0;
		strobes = 0;
		hi10 = 0;
		blim = 1;
		req_kind = EMBH_MEM_DRAM;
		req_write = 0;
		req_valid = 1;
		for (int i = 0; i < 12; i++) begin
			req_addr = 20'h00400 | 20'(i);
			step(1);
			rows += !c1;
			strobes += !c0;
			hi10 += a10 && !c0;
		end
		req_valid = 0;
		repeat (4) begin
			step(1);
			rows += !c1;
			strobes += !c0;
			hi10 += a10 && !c0;
		end
		blim = 0;
		chk("column strobes", strobes, 12);
		chk("rows under limit", rows, 2);
		chk("addr bit ten", hi10, 12);
	endtask : t_burst_limit
	task automatic t_hold_idle;
		int c;
		want_hold = 1;
		wait_ack(1, c);
		chk("idle grant fast", c < 8, 1);
		step(10);
		chk("ack stands", ack, 1);
		chk("bus released", {b_oe, d_oe}, 0);
		want_hold = 0;
		wait_ack(0, c);
		chk("ack drop", c < 8, 1);
		step(2);
		chk("bus driven again", b_oe, 1);
	endtask : t_hold_idle
	task automatic t_block;
		int c;
		gblk = 1;
		want_hold = 1;
		c = 0;
		repeat (60) begin c += ack; step(1); end
		chk("blocked grants", c, 0);
		gblk = 0;
		wait_ack(1, c);
		chk("grant after unblock", c < 8, 1);
		want_hold = 0;
		wait_ack(0, c);
	endtask : t_block
	task automatic t_pending;
		int c, w0;
		w0 = wr_count;
		ready_now = 0;
		// slow ready must pass the pin synchroniser before the word issues
		step(4);
		send(EMBH_MEM_ASYNC, 1, 32'h0000_00C7);
		want_hold = 1;
		repeat (30) begin c += ack; step(1); end
		chk("grant while pending", c, 0);
		ready_now = 1;
		wait_ack(1, c);
		chk("grant after ready", c < 40, 1);
		chk("write done first", wr_count - w0, 1);
		want_hold = 0;
		wait_ack(0, c);
	endtask : t_pending
	task automatic t_fifo_full;
		int c, w0;
		want_hold = 1;
		wait_ack(1, c);
		w0 = wr_count;
		for (int i = 0; i < EMBH_FIFO_DEPTH; i++) send(EMBH_MEM_ASYNC, 1, 32'h10 + i);
		chk("fifo refuses", req_ready, 0);
		chk("no writes in hold", wr_count - w0, 0);
		want_hold = 0;
		step(60);
		chk("fifo drained", wr_count - w0, EMBH_FIFO_DEPTH);
		chk("fifo accepts", req_ready, 1);
	endtask : t_fifo_full
	// ------------------------------------------------------------
	// main sequence and hang guard
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin fail_count++; complete_run; end
	end
	initial begin
		// pll settling stands for a short reset here
		step(8);
		chk("reset ack high", {ack, fclk}, 2'h3);
		chk("reset bus z", {b_oe, d_oe}, 0);
		rstn = 1;
		step(4);
		t_burst_write();
		t_dram_read();
		t_burst_limit();
		t_hold_idle();
		t_block();
		t_pending();
		t_fifo_full();
		complete_run;
	end
endmodule : testbench
`default_nettype wire
